// ==== event_irq_pkg.sv ====
// Constants, register map and types of the event interrupt packetizer.
// Assumes a single controller clock shared by all users of the package.
// Function
// - Axis A motion done queues code 208.
// - All axes motion done queues code 216.
// - Tracking error reaching limit queues 200.
// - Limit hit while moving toward it queues 192.
// - Program thread stopping queues code 219.
// - Input events need event mask bit 15.
// - Low input k queues code 225 plus k.
// - User interrupts report codes 240 to 255.
// - Each packet carries one to sixteen codes.
// - Header 0x01, codes, then count byte.
// - Zero event mask disarms and empties queue.
// - Error, limit, input events disarm after firing.
// - Event mask reads back as last written.
package event_irq_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_EVENT_MASK = 8'h00;
    localparam logic [7:0] OFS_INPUT_MASK = 8'h04;
    localparam logic [7:0] OFS_USER_INT = 8'h08;
    localparam logic [7:0] OFS_QUEUE_STATE = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [15:0] EVENT_MASK_RST = 16'h0000;
    localparam logic [7:0] INPUT_MASK_RST = 8'h00;
    localparam logic [15:0] VALID_EVENT_BITS = 16'hA701;
    localparam int BIT_MOTION_A = 0;
    localparam int BIT_MOTION_ALL = 8;
    localparam int BIT_POS_ERR = 9;
    localparam int BIT_LIMIT = 10;
    localparam int BIT_THREAD = 13;
    localparam int BIT_INPUTS = 15;
    localparam logic [7:0] CODE_MOTION_A = 8'hD0;
    localparam logic [7:0] CODE_MOTION_ALL = 8'hD8;
    localparam logic [7:0] CODE_POS_ERR = 8'hC8;
    localparam logic [7:0] CODE_LIMIT = 8'hC0;
    localparam logic [7:0] CODE_THREAD = 8'hDB;
    localparam logic [7:0] CODE_INPUT_BASE = 8'hE1;
    localparam logic [7:0] CODE_USER_BASE = 8'hF0;
    localparam logic [7:0] PKT_HEADER = 8'h01;
    localparam logic [7:0] PKT_FRAME_BYTES = 8'h02;
    localparam int MAX_CODES = 16;
    localparam int QUEUE_DEPTH = 16;
    localparam int CNT_W = 5;
    localparam int NUM_SRC = 14;
    localparam int SRC_USER = 5;
    localparam int SRC_INPUT0 = 6;
    localparam logic [31:0] THREAD_STOPPED = 32'hFFFFFFFF;
    localparam int IRQ_W = 3;
    localparam int IRQ_QUEUED = 0;
    localparam int IRQ_PKT_DONE = 1;
    localparam int IRQ_USER_LOST = 2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR = 2'b01,
        ST_CODE = 2'b10,
        ST_COUNT = 2'b11
    } pkt_state_e;
endpackage

// ==== level_sync.sv ====
// Two-stage synchroniser for a vector of independent pin levels.
// Assumes each bit is a slow level; no bus coherency is given.
`timescale 1ns/10ps
module level_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_reg <= '1;
            q_o <= '1;
        end
        else
        begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule

// ==== code_queue.sv ====
// Sixteen-entry queue of status codes held in flip-flops.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/10ps
module code_queue
    import event_irq_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic clear_i,
    input wire logic push_i,
    input wire logic [7:0] push_data_i,
    input wire logic pop_i,
    output logic [7:0] head_o,
    output logic [CNT_W-1:0] count_o
);
    logic [7:0] mem_reg [QUEUE_DEPTH];
    logic [3:0] wr_ptr_reg;
    logic [3:0] rd_ptr_reg;

    assign head_o = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk_i)
    begin
        if (push_i)
        begin
            mem_reg[wr_ptr_reg] <= push_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            count_o <= '0;
        end
        else if (clear_i)
        begin
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            count_o <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg + 4'(push_i);
            rd_ptr_reg <= rd_ptr_reg + 4'(pop_i);
            count_o <= count_o + CNT_W'(push_i) - CNT_W'(pop_i);
        end
    end
endmodule

// ==== event_interrupt_packetizer.sv ====
// Event interrupt unit: arms motion, error, limit, program and input
// events, queues their status codes and frames them into packets.
// Assumes an APB master on REF_CLK_I and a byte sink with ready.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
module event_interrupt_packetizer
    import event_irq_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic ARST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [DATA_W-1:0] PWDATA_I,
    output logic [DATA_W-1:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic AXIS_A_MOTION_ACTIVE_I,
    input wire logic ALL_AXES_MOTION_ACTIVE_I,
    input wire logic AXIS_A_DIRECTION_FWD_I,
    input wire logic [31:0] AXIS_TRACKING_ERROR_I,
    input wire logic [31:0] AXIS_ERROR_LIMIT_I,
    input wire logic FORWARD_LIMIT_STATE_N_I,
    input wire logic REVERSE_LIMIT_STATE_N_I,
    input wire logic [31:0] THREAD_EXECUTION_STATE_I,
    input wire logic [7:0] DIGITAL_IN_I,
    output logic [7:0] PKT_DATA_O,
    output logic PKT_VALID_O,
    output logic PKT_LAST_O,
    input wire logic PKT_READY_I,
    output logic IRQ_O
);
    logic [15:0] event_mask_reg;
    logic [7:0] input_mask_reg;
    logic [15:0] arm_reg;
    logic [7:0] input_arm_reg;
    logic [NUM_SRC-1:0] pend_reg;
    logic [NUM_SRC-1:0] det;
    logic [NUM_SRC-1:0] chosen;
    logic [7:0] code_next;
    logic [3:0] user_num_reg;
    logic flush_pend_reg;
    logic motion_a_prev_reg;
    logic motion_all_prev_reg;
    logic thread_prev_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clear;
    logic [1:0] limit_sync;
    logic [7:0] din_sync;
    logic thread_stopped;
    logic limit_hit;
    logic wr_en;
    logic rd_en;
    logic setup;
    logic mask_write;
    logic user_write;
    logic user_lost;
    logic push;
    logic pop;
    logic q_clear;
    logic [7:0] q_head;
    logic [CNT_W-1:0] q_count;
    pkt_state_e state_reg;
    logic [CNT_W-1:0] pkt_len_reg;
    logic [CNT_W-1:0] sent_reg;
    logic rd_status_reg;

    level_sync #(
        .W(2)
    ) limit_sync_u (
        .clk_i(REF_CLK_I),
        .arst_n_i(ARST_N_I),
        .d_i({REVERSE_LIMIT_STATE_N_I, FORWARD_LIMIT_STATE_N_I}),
        .q_o(limit_sync)
    );

    level_sync #(
        .W(8)
    ) input_sync_u (
        .clk_i(REF_CLK_I),
        .arst_n_i(ARST_N_I),
        .d_i(DIGITAL_IN_I),
        .q_o(din_sync)
    );

    code_queue queue_u (
        .clk_i(REF_CLK_I),
        .arst_n_i(ARST_N_I),
        .clear_i(q_clear),
        .push_i(push),
        .push_data_i(code_next),
        .pop_i(pop),
        .head_o(q_head),
        .count_o(q_count)
    );

    // Bus decode: no wait state, write and read-clear at the access edge.
    assign setup = PSEL_I && !PENABLE_I;
    assign wr_en = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    assign rd_en = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I;
    assign mask_write = wr_en && (PADDR_I == OFS_EVENT_MASK);
    assign user_write = wr_en && (PADDR_I == OFS_USER_INT);

    // Condition detection for every event source.
    assign thread_stopped = THREAD_EXECUTION_STATE_I == THREAD_STOPPED;
    assign limit_hit = AXIS_A_MOTION_ACTIVE_I &&
        ((!limit_sync[0] && AXIS_A_DIRECTION_FWD_I) ||
         (!limit_sync[1] && !AXIS_A_DIRECTION_FWD_I));

    always_comb
    begin
        det = '0;
        det[0] = arm_reg[BIT_MOTION_A] && motion_a_prev_reg &&
            !AXIS_A_MOTION_ACTIVE_I;
        det[1] = arm_reg[BIT_MOTION_ALL] && motion_all_prev_reg &&
            !ALL_AXES_MOTION_ACTIVE_I;
        det[2] = arm_reg[BIT_POS_ERR] &&
            (AXIS_TRACKING_ERROR_I >= AXIS_ERROR_LIMIT_I);
        det[3] = arm_reg[BIT_LIMIT] && limit_hit;
        det[4] = arm_reg[BIT_THREAD] && thread_stopped &&
            !thread_prev_reg;
        det[SRC_USER] = user_write;
        for (int k = 0; k < 8; k++)
        begin
            det[SRC_INPUT0 + k] = arm_reg[BIT_INPUTS] &&
                input_arm_reg[k] && !din_sync[k];
        end
        if (mask_write || flush_pend_reg)
        begin
            det = '0;
        end
    end

    // The pending source with the lowest index goes first, whatever its age.
    always_comb
    begin
        chosen = '0;
        code_next = 8'h00;
        for (int s = NUM_SRC - 1; s >= 0; s--)
        begin
            if (pend_reg[s])
            begin
                chosen = '0;
                chosen[s] = 1'b1;
            end
        end
        if (chosen[0])
            code_next = CODE_MOTION_A;
        else if (chosen[1])
            code_next = CODE_MOTION_ALL;
        else if (chosen[2])
            code_next = CODE_POS_ERR;
        else if (chosen[3])
            code_next = CODE_LIMIT;
        else if (chosen[4])
            code_next = CODE_THREAD;
        else if (chosen[SRC_USER])
            code_next = CODE_USER_BASE + {4'h0, user_num_reg};
        else
        begin
            for (int k = 0; k < 8; k++)
            begin
                if (chosen[SRC_INPUT0 + k])
                    code_next = CODE_INPUT_BASE + 8'(k);
            end
        end
    end

    assign push = (|pend_reg) && !flush_pend_reg && !mask_write &&
        (q_count < CNT_W'(QUEUE_DEPTH));
    assign q_clear = flush_pend_reg && (state_reg == ST_IDLE);
    assign pop = ((state_reg == ST_HDR) || (state_reg == ST_CODE)) &&
        PKT_READY_I && (sent_reg < pkt_len_reg);
    assign user_lost = user_write && pend_reg[SRC_USER] &&
        !(push && chosen[SRC_USER]);

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            pend_reg <= '0;
        else if (mask_write && (PWDATA_I[15:0] == 16'h0000))
            pend_reg <= '0;
        else
            pend_reg <= (pend_reg & ~(push ? chosen : '0)) | det;
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            motion_a_prev_reg <= 1'b0;
            motion_all_prev_reg <= 1'b0;
            thread_prev_reg <= 1'b0;
        end
        else
        begin
            motion_a_prev_reg <= AXIS_A_MOTION_ACTIVE_I;
            motion_all_prev_reg <= ALL_AXES_MOTION_ACTIVE_I;
            thread_prev_reg <= thread_stopped;
        end
    end

    // Mask storage, arming and self-disarming sources.
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            event_mask_reg <= EVENT_MASK_RST;
            input_mask_reg <= INPUT_MASK_RST;
            arm_reg <= EVENT_MASK_RST;
            input_arm_reg <= INPUT_MASK_RST;
            user_num_reg <= 4'h0;
            irq_mask_reg <= '0;
        end
        else
        begin
            if (mask_write)
            begin
                event_mask_reg <= PWDATA_I[15:0];
                arm_reg <= PWDATA_I[15:0] & VALID_EVENT_BITS;
                input_arm_reg <= input_mask_reg;
            end
            else
            begin
                if (det[2])
                    arm_reg[BIT_POS_ERR] <= 1'b0;
                if (det[3])
                    arm_reg[BIT_LIMIT] <= 1'b0;
                input_arm_reg <= input_arm_reg &
                    ~det[SRC_INPUT0 +: 8];
            end
            if (wr_en && (PADDR_I == OFS_INPUT_MASK))
                input_mask_reg <= PWDATA_I[7:0];
            if (user_write)
                user_num_reg <= PWDATA_I[3:0];
            if (wr_en && (PADDR_I == OFS_IRQ_MASK))
                irq_mask_reg <= PWDATA_I[IRQ_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            flush_pend_reg <= 1'b0;
        else if (mask_write && (PWDATA_I[15:0] == 16'h0000))
            flush_pend_reg <= 1'b1;
        else if (q_clear)
            flush_pend_reg <= 1'b0;
    end

    // Packet framer: header, one to sixteen codes, then the byte count.
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            state_reg <= ST_IDLE;
            pkt_len_reg <= '0;
            sent_reg <= '0;
            PKT_DATA_O <= 8'h00;
            PKT_VALID_O <= 1'b0;
            PKT_LAST_O <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if ((q_count != '0) && !flush_pend_reg)
                    begin
                        pkt_len_reg <= (q_count > CNT_W'(MAX_CODES)) ?
                            CNT_W'(MAX_CODES) : q_count;
                        sent_reg <= '0;
                        PKT_DATA_O <= PKT_HEADER;
                        PKT_VALID_O <= 1'b1;
                        state_reg <= ST_HDR;
                    end
                end
                ST_HDR, ST_CODE:
                begin
                    if (PKT_READY_I)
                    begin
                        if (pop)
                        begin
                            PKT_DATA_O <= q_head;
                            sent_reg <= sent_reg + CNT_W'(1);
                            state_reg <= ST_CODE;
                        end
                        else
                        begin
                            PKT_DATA_O <= {3'b000, pkt_len_reg} +
                                PKT_FRAME_BYTES;
                            PKT_LAST_O <= 1'b1;
                            state_reg <= ST_COUNT;
                        end
                    end
                end
                ST_COUNT:
                begin
                    if (PKT_READY_I)
                    begin
                        PKT_VALID_O <= 1'b0;
                        PKT_LAST_O <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // Sticky interrupt status; a read clears only what it returned.
    assign irq_set[IRQ_QUEUED] = push;
    assign irq_set[IRQ_PKT_DONE] = (state_reg == ST_COUNT) && PKT_READY_I;
    assign irq_set[IRQ_USER_LOST] = user_lost;
    assign irq_clear = (rd_en && rd_status_reg) ?
        PRDATA_O[IRQ_W-1:0] : '0;

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            irq_status_reg <= '0;
            IRQ_O <= 1'b0;
        end
        else
        begin
            irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_set;
            IRQ_O <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // Bus slave: data and error are captured in the setup cycle.
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            PRDATA_O <= '0;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            rd_status_reg <= 1'b0;
        end
        else
        begin
            PREADY_O <= setup;
            PSLVERR_O <= 1'b0;
            rd_status_reg <= 1'b0;
            PRDATA_O <= '0;
            if (setup)
            begin
                if (PADDR_I == OFS_EVENT_MASK)
                    PRDATA_O <= {16'h0000, event_mask_reg};
                else if (PADDR_I == OFS_INPUT_MASK)
                    PRDATA_O <= {24'h000000, input_mask_reg};
                else if (PADDR_I == OFS_USER_INT)
                    PRDATA_O <= {28'h0000000, user_num_reg};
                else if (PADDR_I == OFS_QUEUE_STATE)
                    PRDATA_O <= {arm_reg, input_arm_reg, 1'b0,
                        state_reg, q_count};
                else if (PADDR_I == OFS_IRQ_STATUS)
                begin
                    PRDATA_O <= {29'h0000000, irq_status_reg};
                    rd_status_reg <= !PWRITE_I;
                end
                else if (PADDR_I == OFS_IRQ_MASK)
                    PRDATA_O <= {29'h0000000, irq_mask_reg};
                else
                    PSLVERR_O <= 1'b1;
            end
        end
    end
endmodule

// ==== event_interrupt_packetizer_checker.sv ====
// Port checker for the event interrupt packetizer.
// Assumes it is bound to the top module by the statement at its foot.
`timescale 1ns/10ps
module event_interrupt_packetizer_checker
    import event_irq_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic ARST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic [DATA_W-1:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic [7:0] PKT_DATA_O,
    input wire logic PKT_VALID_O,
    input wire logic PKT_LAST_O,
    input wire logic PKT_READY_I
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    logic [4:0] seen_reg;
    logic take;
    assign take = PKT_VALID_O && PKT_READY_I;
    // Counts bytes taken in the current packet before its count byte.
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            seen_reg <= 5'h00;
        else if (take)
            seen_reg <= PKT_LAST_O ? 5'h00 : seen_reg + 5'h01;
    end
    apb_ready_a: assert property (
        PSEL_I && !PENABLE_I ##1 PSEL_I && PENABLE_I |-> PREADY_O)
        else $error("access cycle without ready");
    ready_once_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held too long");
    slave_err_a: assert property (
        PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h00000000)
        else $error("error response malformed");
    idle_rdata_a: assert property (
        !PREADY_O |-> PRDATA_O == 32'h00000000)
        else $error("read data outside access");
    pkt_header_a: assert property (
        $rose(PKT_VALID_O) |-> PKT_DATA_O == PKT_HEADER && !PKT_LAST_O)
        else $error("packet does not open with header");
    byte_hold_a: assert property (
        PKT_VALID_O && !PKT_READY_I |=> PKT_VALID_O
        && $stable(PKT_DATA_O) && $stable(PKT_LAST_O))
        else $error("byte changed before taken");
    pkt_count_a: assert property (
        PKT_LAST_O |-> PKT_DATA_O == {3'h0, seen_reg} + 8'h01)
        else $error("count byte wrong");
    code_bound_a: assert property (
        PKT_LAST_O |-> seen_reg >= 5'h02 && seen_reg <= 5'h11)
        else $error("packet code count out of range");
    pkt_gap_a: assert property (take && PKT_LAST_O |=> !PKT_VALID_O)
        else $error("no idle cycle after packet");
endmodule
bind event_interrupt_packetizer event_interrupt_packetizer_checker i_chk (
    .REF_CLK_I(REF_CLK_I),
    .ARST_N_I(ARST_N_I),
    .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I),
    .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O),
    .PKT_DATA_O(PKT_DATA_O),
    .PKT_VALID_O(PKT_VALID_O),
    .PKT_LAST_O(PKT_LAST_O),
    .PKT_READY_I(PKT_READY_I)
);

// ==== pkt_host_sink.sv ====
// Host model that takes interrupt packet bytes and reports each one.
// Assumes the packetizer clock; slow mode is ready every other cycle.
`timescale 1ns/10ps
module pkt_host_sink (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic stall_i,
    input wire logic slow_i,
    input wire logic [7:0] data_i,
    input wire logic valid_i,
    input wire logic last_i,
    output logic ready_o,
    output logic got_o,
    output logic [7:0] got_data_o,
    output logic got_last_o
);
    logic phase_reg;
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            phase_reg <= 1'b0;
        else
            phase_reg <= ~phase_reg;
    end
    assign ready_o = !stall_i && (!slow_i || phase_reg);
    // Each taken byte is reported one cycle later for framing checks.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            got_o <= 1'b0;
        else
            got_o <= valid_i && ready_o;
    end
    always_ff @(posedge clk_i)
    begin
        got_data_o <= data_i;
        got_last_o <= last_i;
    end
endmodule

// ==== event_interrupt_packetizer_tb.sv ====
// Self-checking testbench of the event interrupt packetizer.
// Assumes the bound checker and the host sink model are compiled first.
`timescale 1ns/10ps
module event_interrupt_packetizer_tb;
    import event_irq_pkg::*;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, slv;
    logic [7:0] paddr, din, pdata, got_data;
    logic [31:0] pwdata, prdata, trk, lim, thr;
    logic mot_a, mot_all, fwd, lf_n, lr_n, irq, in_pkt;
    logic pvalid, plast, hrdy, stall, slow, got, got_last;
    int err_total, total_checks, cycles, ncodes;
    logic [7:0] rx[$];
    logic [7:0] exp[$];
    event_interrupt_packetizer i_dut (
        .REF_CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .AXIS_A_MOTION_ACTIVE_I(mot_a),
        .ALL_AXES_MOTION_ACTIVE_I(mot_all), .AXIS_A_DIRECTION_FWD_I(fwd),
        .AXIS_TRACKING_ERROR_I(trk), .AXIS_ERROR_LIMIT_I(lim),
        .FORWARD_LIMIT_STATE_N_I(lf_n), .REVERSE_LIMIT_STATE_N_I(lr_n),
        .THREAD_EXECUTION_STATE_I(thr), .DIGITAL_IN_I(din),
        .PKT_DATA_O(pdata), .PKT_VALID_O(pvalid), .PKT_LAST_O(plast),
        .PKT_READY_I(hrdy), .IRQ_O(irq));
    pkt_host_sink i_host (
        .clk_i(clk), .arst_n_i(arst_n), .stall_i(stall), .slow_i(slow),
        .data_i(pdata), .valid_i(pvalid), .last_i(plast), .ready_o(hrdy),
        .got_o(got), .got_data_o(got_data), .got_last_o(got_last));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic give_verdict();
        if (err_total == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            err_total++;
            $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total++;
            give_verdict();
        end
    end
    // Splits the byte stream from the host model into packets.
    always @(posedge clk)
    begin
        if (got === 1'b1)
        begin
            if (!in_pkt)
            begin
                chk(got_data, PKT_HEADER);
                in_pkt = 1'b1;
                ncodes = 0;
            end
            else if (got_last === 1'b1)
            begin
                chk(got_data, ncodes + 2);
                chk(ncodes >= 1 && ncodes <= 16, 1);
                in_pkt = 1'b0;
            end
            else
            begin
                rx.push_back(got_data);
                ncodes++;
            end
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        r = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic drain();
        int i;
        i = 0;
        while (rx.size() < exp.size() && i < 400)
        begin
            @(posedge clk);
            i++;
        end
        cyc(40);
        chk(rx.size(), exp.size());
        foreach (exp[k])
            if (k < rx.size())
                chk(rx[k], exp[k]);
        rx.delete();
        exp.delete();
    endtask
    task automatic t_regs();
        logic [31:0] r;
        apb(1'b0, OFS_EVENT_MASK, 32'h00000000, r);
        chk(r, 32'h00000000);
        wr(OFS_EVENT_MASK, 32'h00001234);
        apb(1'b0, OFS_EVENT_MASK, 32'h00000000, r);
        chk(r, 32'h00001234);
        apb(1'b0, 8'h20, 32'h00000000, r);
        chk({r[30:0], slv}, 32'h00000001);
        mot_a <= 1'b0;
        thr <= 32'hFFFFFFFF;
        wr(OFS_EVENT_MASK, 32'h000058FE);
        apb(1'b0, OFS_QUEUE_STATE, 32'h00000000, r);
        chk(r[31:16], 32'h00000000);
        mot_all <= 1'b0;
        trk <= 32'hFFFFFFFF;
        lf_n <= 1'b0;
        din <= 8'h00;
        drain();
        mot_a <= 1'b1;
        mot_all <= 1'b1;
        thr <= 32'h00000000;
        trk <= 32'h00000000;
        lf_n <= 1'b1;
        din <= 8'hFF;
        wr(OFS_EVENT_MASK, 32'h00000000);
    endtask
    task automatic t_motion();
        wr(OFS_EVENT_MASK, 32'h00002101);
        mot_a <= 1'b0;
        cyc(3);
        mot_all <= 1'b0;
        cyc(3);
        thr <= 32'hFFFFFFFF;
        cyc(3);
        mot_a <= 1'b1;
        mot_all <= 1'b1;
        thr <= 32'h00000000;
        cyc(3);
        mot_a <= 1'b0;
        exp = '{8'hD0, 8'hD8, 8'hDB, 8'hD0};
        drain();
        mot_a <= 1'b1;
        wr(OFS_EVENT_MASK, 32'h00000000);
    endtask
    task automatic t_err_lim();
        trk <= 32'h00000100;
        lim <= 32'h00000101;
        wr(OFS_EVENT_MASK, 32'h00000600);
        cyc(5);
        trk <= 32'h00000101;
        cyc(10);
        lr_n <= 1'b0;
        cyc(10);
        lf_n <= 1'b0;
        exp = '{8'hC8, 8'hC0};
        drain();
        lf_n <= 1'b1;
        lr_n <= 1'b1;
        trk <= 32'h00000000;
        wr(OFS_EVENT_MASK, 32'h00000000);
    endtask
    task automatic t_inputs();
        wr(OFS_INPUT_MASK, 32'h000000A5);
        wr(OFS_EVENT_MASK, 32'h00000001);
        din <= 8'h00;
        drain();
        din <= 8'hFF;
        wr(OFS_EVENT_MASK, 32'h00008000);
        din <= 8'h00;
        cyc(20);
        din <= 8'hFF;
        exp = '{8'hE1, 8'hE3, 8'hE6, 8'hE8};
        drain();
        wr(OFS_EVENT_MASK, 32'h00008000);
        din <= 8'h7F;
        exp = '{8'hE8};
        drain();
        din <= 8'hFF;
        wr(OFS_EVENT_MASK, 32'h00000000);
    endtask
    task automatic t_user();
        logic [31:0] r;
        slow <= 1'b1;
        wr(OFS_IRQ_MASK, 32'h00000001);
        apb(1'b0, OFS_IRQ_STATUS, 32'h00000000, r);
        for (int n = 0; n < 16; n++)
        begin
            wr(OFS_USER_INT, n);
            exp.push_back(8'hF0 + n);
        end
        cyc(3);
        chk(irq, 1'b1);
        drain();
        apb(1'b0, OFS_IRQ_STATUS, 32'h00000000, r);
        chk(r[2:0], 32'h00000003);
        cyc(3);
        chk(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h00000000);
        wr(OFS_USER_INT, 32'h0000000F);
        cyc(3);
        chk(irq, 1'b0);
        exp = '{8'hFF};
        drain();
        slow <= 1'b0;
    endtask
    task automatic t_clear();
        stall <= 1'b1;
        wr(OFS_EVENT_MASK, 32'h00000001);
        wr(OFS_USER_INT, 32'h00000002);
        wr(OFS_USER_INT, 32'h00000003);
        wr(OFS_USER_INT, 32'h00000004);
        wr(OFS_EVENT_MASK, 32'h00000000);
        stall <= 1'b0;
        exp = '{8'hF2};
        drain();
    endtask
    initial
    begin
        {psel, penable, pwrite, slv, in_pkt, stall, slow} = 7'h00;
        {paddr, pwdata, trk, thr} = 104'h0;
        {mot_a, mot_all, fwd, lf_n, lr_n} = 5'h1F;
        lim = 32'hFFFFFFFF;
        din = 8'hFF;
        {err_total, total_checks, cycles, ncodes} = 128'h0;
        arst_n = 1'b0;
        cyc(6);
        arst_n <= 1'b1;
        t_regs();
        t_motion();
        t_err_lim();
        t_inputs();
        t_user();
        t_clear();
        give_verdict();
    end
endmodule
